// file: ucpc_pkg.sv
// constants and carrier types for the dual serial channel pin logic
package ucpc_pkg;
	localparam int CH        = 2;
	localparam int DW        = 8;
	localparam int AW        = 3;
	localparam int BUF_DEPTH = 2;

	// register offsets within one channel
	localparam logic [AW-1:0] OFS_DATA       = 3'h0;
	localparam logic [AW-1:0] OFS_IER        = 3'h1;
	localparam logic [AW-1:0] OFS_FCR        = 3'h2;
	localparam logic [AW-1:0] OFS_MODEM_CTL  = 3'h4;
	localparam logic [AW-1:0] OFS_LSR        = 3'h5;
	localparam logic [AW-1:0] OFS_MODEM_STAT = 3'h6;
	localparam logic [AW-1:0] OFS_ENH_FEAT   = 3'h7;

	// field positions
	localparam int IER_RX   = 0;
	localparam int IER_TX   = 1;
	localparam int IER_MS   = 3;
	localparam int FCR_EN   = 0;
	localparam int MC_RTS   = 1;
	localparam int MC_OUT   = 3;
	localparam int MC_LOOP  = 4;
	localparam int EF_ARTS  = 6;
	localparam int LSR_DR   = 0;
	localparam int LSR_THRE = 5;
	localparam int LSR_TEMT = 6;
	localparam int MS_TERI  = 2;
	localparam int MS_RI    = 6;

	// reset values
	localparam logic [DW-1:0] REG_RST   = 8'h00;
	localparam logic          LINE_IDLE = 1'h1;
	localparam logic          PIN_OFF_N = 1'h1;

	// every asynchronous pin that passes the synchroniser
	typedef struct packed {
		logic          wr_n;
		logic          rd_n;
		logic [CH-1:0] cs_n;
		logic [CH-1:0] ri_n;
		logic [CH-1:0] rx;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
	} ucpc_pins_t;
endpackage

// file: ucpc_buf.sv
// two-entry shift buffer with valid and ready on both sides
`timescale 1ns/1ns
module ucpc_buf #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic              empty,
	output logic              full
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_reg [DEPTH];
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic          valid_reg;
	logic          ready_reg;
	logic          push;
	logic          pop;

	assign count_next = count_reg + CW'(push) - CW'(pop);
	// flags held in flops so both handshakes leave the block registered
	assign full      = ~ready_reg;
	assign empty     = ~valid_reg;
	assign in_ready  = ready_reg;
	assign out_valid = valid_reg;
	assign out_data  = mem_reg[0];
	assign pop       = valid_reg & out_ready;
	assign push      = in_valid & ready_reg;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			count_reg <= '0;
			valid_reg <= 1'h0;
			ready_reg <= 1'h1;
		end
		else
		begin
			count_reg <= count_next;
			valid_reg <= count_next != '0;
			ready_reg <= count_next != CW'(DEPTH);
		end
	end

	// head kept in entry 0 so the output is a flop, not a mux
	always_ff @(posedge core_clk)
	begin
		for (int i = 0; i < DEPTH; i++)
		begin
			if (pop && i < DEPTH - 1)
				mem_reg[i] <= mem_reg[i + 1];
			if (push && (int'(count_reg) - int'(pop)) == i)
				mem_reg[i] <= in_data;
		end
	end
endmodule

// file: ucpc_top.sv
// pin-level control of two serial channels behind an 8-bit host bus
//
// How it works
// - write strobe rising edge stores bus data into addressed register
// - read strobe falling edge puts addressed register on data bus
// - interrupt output is high when active
// - control bit 3 set: interrupt output driven, user output low
// - control bit 3 clear: interrupt output floated, user output high
// - user output high after reset
// - reset returns every register and output to its reset value, except the transmit and receive buffer entries
// - reset disables serial output and serial input
// - ring indicator low-to-high raises modem status interrupt when enabled
// - ring indicator level readable in modem status register
// - control bit 1 set drives request-to-send low, clear drives high
// - request-to-send high after reset
// - request-to-send follows receive space only with automatic mode bit
// - loopback ignores serial input and feeds transmit data to receiver
// - loopback disables serial output pin
// - receive ready goes low when receive buffer holds a character
// - receive ready returns high when receive buffer empties
// - transmit ready low when enough space free or buffer empty
// - transmit ready high when buffer full or not empty
`timescale 1ns/1ns
module ucpc_top (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] host_addr,
	input  wire logic [7:0] host_data_in,
	output logic [7:0]      host_data_out,
	output logic            host_data_oe,
	input  wire logic       host_write_strobe_n,
	input  wire logic       host_read_strobe_n,
	input  wire logic       channel_a_select_n,
	input  wire logic       channel_b_select_n,
	input  wire logic       ring_indicator_a_n,
	input  wire logic       ring_indicator_b_n,
	input  wire logic       serial_in_a,
	input  wire logic       serial_in_b,
	output logic            serial_out_a,
	output logic            serial_out_b,
	output logic            request_to_send_a_n,
	output logic            request_to_send_b_n,
	output logic            user_output_a,
	output logic            user_output_b,
	output logic            irq_out_a,
	output logic            irq_out_b,
	output logic            irq_oe_a,
	output logic            irq_oe_b,
	output logic            receive_ready_a_n,
	output logic            receive_ready_b_n,
	output logic            transmit_ready_a_n,
	output logic            transmit_ready_b_n,
	output logic [7:0]      tx_data_a,
	output logic [7:0]      tx_data_b,
	output logic            tx_valid_a,
	output logic            tx_valid_b,
	input  wire logic       tx_ready_a,
	input  wire logic       tx_ready_b,
	input  wire logic       tx_line_a,
	input  wire logic       tx_line_b,
	output logic            rx_line_a,
	output logic            rx_line_b,
	input  wire logic [7:0] rx_data_a,
	input  wire logic [7:0] rx_data_b,
	input  wire logic       rx_valid_a,
	input  wire logic       rx_valid_b,
	output logic            rx_ready_a,
	output logic            rx_ready_b
);
	ucpc_pkg::ucpc_pins_t pin_now;
	ucpc_pkg::ucpc_pins_t sync1_reg;
	ucpc_pkg::ucpc_pins_t sync2_reg;
	ucpc_pkg::ucpc_pins_t prev_reg;

	logic                        wr_rise;
	logic                        rd_fall;
	logic [ucpc_pkg::CH-1:0]     sel;
	logic [ucpc_pkg::CH-1:0]     tx_ready_v;
	logic [ucpc_pkg::CH-1:0]     tx_line_v;
	logic [ucpc_pkg::CH-1:0]     rx_valid_v;
	logic [ucpc_pkg::DW-1:0]     rx_data_v [ucpc_pkg::CH];
	logic [7:0]                  data_out_reg;
	logic                        data_oe_reg;

	assign pin_now = {host_write_strobe_n, host_read_strobe_n,
		channel_b_select_n, channel_a_select_n,
		ring_indicator_b_n, ring_indicator_a_n,
		serial_in_b, serial_in_a, host_addr, host_data_in};
	assign tx_ready_v   = {tx_ready_b, tx_ready_a};
	assign tx_line_v    = {tx_line_b, tx_line_a};
	assign rx_valid_v   = {rx_valid_b, rx_valid_a};
	assign rx_data_v[0] = rx_data_a;
	assign rx_data_v[1] = rx_data_b;

	// two-stage synchroniser
	// address and data ride the same stages so they stay aligned to the strobes
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			sync1_reg <= '1;
			sync2_reg <= '1;
			prev_reg  <= '1;
		end
		else
		begin
			sync1_reg <= pin_now;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign wr_rise = sync2_reg.wr_n & ~prev_reg.wr_n;
	assign rd_fall = ~sync2_reg.rd_n & prev_reg.rd_n;
	assign sel = ~sync2_reg.cs_n;

	// one copy of the channel logic per channel
	for (genvar c = 0; c < ucpc_pkg::CH; c++)
	begin : g_ch
		logic [7:0]              ier_reg;
		logic [7:0]              fcr_reg;
		logic [7:0]              modem_control_reg;
		logic [7:0]              enhanced_feature_reg;
		logic                    teri_reg;
		logic                    uo_reg;
		logic                    irq_reg;
		logic                    irq_oe_reg;
		logic                    rts_n_reg;
		logic                    rxrdy_n_reg;
		logic                    txrdy_n_reg;
		logic                    sout_reg;
		logic                    rxl_reg;
		logic                    wr_hit;
		logic                    rd_hit;
		logic                    loop;
		logic                    ri_rise;
		logic                    cause;
		logic [7:0]              rd_val;
		logic                    tx_in_ready;
		logic                    tx_empty;
		logic                    tx_full;
		logic [7:0]              txo_data;
		logic                    txo_valid;
		logic                    rx_in_ready;
		logic [7:0]              rxo_data;
		logic                    rxo_valid;
		logic                    rx_pop;
		logic                    rx_empty;
		logic                    rx_full;

		assign wr_hit = wr_rise & sel[c];
		// channel A wins a read when both selects are low
		assign rd_hit = rd_fall & sel[c] & ((c == 0) | ~sel[0]);
		assign loop   = modem_control_reg[ucpc_pkg::MC_LOOP];
		// pin rising edge ends a ring
		assign ri_rise = sync2_reg.ri_n[c] & ~prev_reg.ri_n[c];
		assign rx_pop  = rd_hit & (sync2_reg.addr == ucpc_pkg::OFS_DATA);

		always_ff @(posedge core_clk)
		begin
			if (!rst_n)
			begin
				ier_reg <= ucpc_pkg::REG_RST;
				fcr_reg <= ucpc_pkg::REG_RST;
				modem_control_reg    <= ucpc_pkg::REG_RST;
				enhanced_feature_reg <= ucpc_pkg::REG_RST;
			end
			else if (wr_hit)
			begin
				if (sync2_reg.addr == ucpc_pkg::OFS_IER)
					ier_reg <= sync2_reg.data;
				else if (sync2_reg.addr == ucpc_pkg::OFS_FCR)
					fcr_reg <= sync2_reg.data;
				else if (sync2_reg.addr == ucpc_pkg::OFS_MODEM_CTL)
					modem_control_reg <= sync2_reg.data;
				else if (sync2_reg.addr == ucpc_pkg::OFS_ENH_FEAT)
					enhanced_feature_reg <= sync2_reg.data;
			end
		end

		// sticky ring flag, set beats the clearing read
		always_ff @(posedge core_clk)
		begin
			if (!rst_n)
				teri_reg <= 1'h0;
			else if (ri_rise)
				teri_reg <= 1'h1;
			else if (rd_hit && sync2_reg.addr == ucpc_pkg::OFS_MODEM_STAT)
				teri_reg <= 1'h0;
		end

		// read value of the addressed register
		always_comb
		begin
			rd_val = ucpc_pkg::REG_RST;
			if (sync2_reg.addr == ucpc_pkg::OFS_DATA)
				rd_val = rxo_valid ? rxo_data : ucpc_pkg::REG_RST;
			else if (sync2_reg.addr == ucpc_pkg::OFS_IER)
				rd_val = ier_reg;
			else if (sync2_reg.addr == ucpc_pkg::OFS_MODEM_CTL)
				rd_val = modem_control_reg;
			else if (sync2_reg.addr == ucpc_pkg::OFS_LSR)
			begin
				rd_val[ucpc_pkg::LSR_DR]   = rxo_valid;
				rd_val[ucpc_pkg::LSR_THRE] = ~tx_full;
				rd_val[ucpc_pkg::LSR_TEMT] = tx_empty;
			end
			else if (sync2_reg.addr == ucpc_pkg::OFS_MODEM_STAT)
			begin
				rd_val[ucpc_pkg::MS_RI]   = ~sync2_reg.ri_n[c];
				rd_val[ucpc_pkg::MS_TERI] = teri_reg;
			end
			else if (sync2_reg.addr == ucpc_pkg::OFS_ENH_FEAT)
				rd_val = enhanced_feature_reg;
		end

		assign cause = (ier_reg[ucpc_pkg::IER_MS] & teri_reg)
			| (ier_reg[ucpc_pkg::IER_RX] & rxo_valid)
			| (ier_reg[ucpc_pkg::IER_TX] & tx_empty);

		// pin outputs return to reset values
		always_ff @(posedge core_clk)
		begin
			if (!rst_n)
			begin
				uo_reg      <= ucpc_pkg::PIN_OFF_N;
				irq_reg     <= 1'h0;
				irq_oe_reg  <= 1'h0;
				rts_n_reg   <= ucpc_pkg::PIN_OFF_N;
				rxrdy_n_reg <= ucpc_pkg::PIN_OFF_N;
				txrdy_n_reg <= ucpc_pkg::PIN_OFF_N;
			end
			else
			begin
				uo_reg     <= ~modem_control_reg[ucpc_pkg::MC_OUT];
				irq_oe_reg <= modem_control_reg[ucpc_pkg::MC_OUT];
				irq_reg    <= modem_control_reg[ucpc_pkg::MC_OUT] & cause;
				// control bit drives the pin inverted
				// automatic mode also drives it high when receive space runs out
				rts_n_reg  <= ~(modem_control_reg[ucpc_pkg::MC_RTS]
					& (~enhanced_feature_reg[ucpc_pkg::EF_ARTS] | ~rx_full));
				rxrdy_n_reg <= rx_empty;
				// high on full or not empty
				txrdy_n_reg <= fcr_reg[ucpc_pkg::FCR_EN] ? tx_full : ~tx_empty;
			end
		end

		always_ff @(posedge core_clk)
		begin
			if (!rst_n)
			begin
				sout_reg <= ucpc_pkg::LINE_IDLE;
				rxl_reg  <= ucpc_pkg::LINE_IDLE;
			end
			else
			begin
				sout_reg <= loop ? ucpc_pkg::LINE_IDLE : tx_line_v[c];
				// receiver fed from transmit line in loopback
				rxl_reg  <= loop ? tx_line_v[c] : sync2_reg.rx[c];
			end
		end

		// host writes into a full buffer are lost; the ready pin warns first
		ucpc_buf #(
			.W     (ucpc_pkg::DW),
			.DEPTH (ucpc_pkg::BUF_DEPTH)
		) u_tx_buf (
			.core_clk  (core_clk),
			.rst_n     (rst_n),
			.in_data   (sync2_reg.data),
			.in_valid  (wr_hit && sync2_reg.addr == ucpc_pkg::OFS_DATA),
			.in_ready  (tx_in_ready),
			.out_data  (txo_data),
			.out_valid (txo_valid),
			.out_ready (tx_ready_v[c]),
			.empty     (tx_empty),
			.full      (tx_full)
		);

		ucpc_buf #(
			.W     (ucpc_pkg::DW),
			.DEPTH (ucpc_pkg::BUF_DEPTH)
		) u_rx_buf (
			.core_clk  (core_clk),
			.rst_n     (rst_n),
			.in_data   (rx_data_v[c]),
			.in_valid  (rx_valid_v[c]),
			.in_ready  (rx_in_ready),
			.out_data  (rxo_data),
			.out_valid (rxo_valid),
			.out_ready (rx_pop),
			.empty     (rx_empty),
			.full      (rx_full)
		);
	end

	// data bus capture on read edge
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			data_out_reg <= ucpc_pkg::REG_RST;
			data_oe_reg  <= 1'h0;
		end
		else
		begin
			data_oe_reg <= ~sync2_reg.rd_n & (|sel);
			if (rd_fall && sel[0])
				data_out_reg <= g_ch[0].rd_val;
			else if (rd_fall && sel[1])
				data_out_reg <= g_ch[1].rd_val;
		end
	end

	assign host_data_out       = data_out_reg;
	assign host_data_oe        = data_oe_reg;
	assign serial_out_a        = g_ch[0].sout_reg;
	assign serial_out_b        = g_ch[1].sout_reg;
	assign rx_line_a           = g_ch[0].rxl_reg;
	assign rx_line_b           = g_ch[1].rxl_reg;
	assign request_to_send_a_n = g_ch[0].rts_n_reg;
	assign request_to_send_b_n = g_ch[1].rts_n_reg;
	assign user_output_a       = g_ch[0].uo_reg;
	assign user_output_b       = g_ch[1].uo_reg;
	assign irq_out_a           = g_ch[0].irq_reg;
	assign irq_out_b           = g_ch[1].irq_reg;
	assign irq_oe_a            = g_ch[0].irq_oe_reg;
	assign irq_oe_b            = g_ch[1].irq_oe_reg;
	assign receive_ready_a_n   = g_ch[0].rxrdy_n_reg;
	assign receive_ready_b_n   = g_ch[1].rxrdy_n_reg;
	assign transmit_ready_a_n  = g_ch[0].txrdy_n_reg;
	assign transmit_ready_b_n  = g_ch[1].txrdy_n_reg;
	assign tx_data_a           = g_ch[0].txo_data;
	assign tx_data_b           = g_ch[1].txo_data;
	assign tx_valid_a          = g_ch[0].txo_valid;
	assign tx_valid_b          = g_ch[1].txo_valid;
	assign rx_ready_a          = g_ch[0].rx_in_ready;
	assign rx_ready_b          = g_ch[1].rx_in_ready;
endmodule

// file: ucpc_top_chk.sv
// concurrent checks on the pins of the dual channel block
`timescale 1ns/1ns
module ucpc_top_chk (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       host_read_strobe_n,
	input wire logic       channel_a_select_n,
	input wire logic       channel_b_select_n,
	input wire logic       host_data_oe,
	input wire logic       user_output_a,
	input wire logic       user_output_b,
	input wire logic       irq_out_a,
	input wire logic       irq_oe_a,
	input wire logic       irq_oe_b,
	input wire logic       serial_out_a,
	input wire logic       tx_line_a,
	input wire logic [7:0] tx_data_a,
	input wire logic       tx_valid_a,
	input wire logic       tx_ready_a,
	input wire logic       rx_valid_a,
	input wire logic       rx_ready_a,
	input wire logic       receive_ready_a_n
);
	logic rd_sel;
	assign rd_sel = !host_read_strobe_n && !(channel_a_select_n && channel_b_select_n);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_push_a;
		rx_valid_a && rx_ready_a && receive_ready_a_n;
	endsequence
	sequence s_stall_a;
		tx_valid_a && !tx_ready_a;
	endsequence
	a_user_irq_a: assert property (user_output_a == !irq_oe_a)
		else $error("user output a and irq enable a disagree");
	a_user_irq_b: assert property (user_output_b == !irq_oe_b)
		else $error("user output b and irq enable b disagree");
	a_irq_gate_a: assert property (!irq_oe_a |-> !irq_out_a)
		else $error("irq a active while not driven");
	a_read_oe: assert property ($rose(host_data_oe) |-> $past(rd_sel, 2))
		else $error("data bus driven without selected read");
	a_rx_push_a: assert property (s_push_a |-> ##2 !receive_ready_a_n)
		else $error("receive ready a missed first word");
	a_rx_full_a: assert property (!rx_ready_a |-> !receive_ready_a_n)
		else $error("receive ready a high with full buffer");
	a_tx_follow_a: assert property (!serial_out_a |-> !$past(tx_line_a))
		else $error("serial out a low without line low");
	a_tx_hold_a: assert property (s_stall_a |=> tx_valid_a && $stable(tx_data_a))
		else $error("stalled transmit word a changed");
endmodule
bind ucpc_top ucpc_top_chk u_chk (.core_clk, .rst_n, .host_read_strobe_n, .channel_a_select_n,
	.channel_b_select_n, .host_data_oe, .user_output_a, .user_output_b, .irq_out_a, .irq_oe_a,
	.irq_oe_b, .serial_out_a, .tx_line_a, .tx_data_a, .tx_valid_a, .tx_ready_a, .rx_valid_a,
	.rx_ready_a, .receive_ready_a_n);

// file: ucpc_far.sv
// serializer and deserializer stand-in for one channel stream
`timescale 1ns/1ns
module ucpc_far (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       stall,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	output logic            tx_line,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	input  wire logic       rx_ready
);
	logic [7:0] got[$];
	logic [7:0] send[$];
	logic [9:0] frame;
	// one word in flight; stall backs the buffer up
	assign tx_ready = !stall && frame == 10'h000;
	assign tx_line  = frame == 10'h000 ? 1'h1 : frame[0];
	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			frame    <= 10'h000;
			rx_valid <= 1'h0;
			rx_data  <= 8'h00;
		end
		else
		begin
			if (tx_valid && tx_ready)
			begin
				got.push_back(tx_data);
				frame <= {1'h1, tx_data, 1'h0};
			end
			else
				frame <= frame >> 1;
			if (rx_valid && rx_ready)
				send.delete(0);
			rx_valid <= send.size() != 0;
			// idle data inverts so a stale word never looks valid
			rx_data  <= send.size() != 0 ? send[0] : ~rx_data;
		end
	end
endmodule

// file: ucpc_top_tb.sv
// self-checking bench for the dual channel pin block
`timescale 1ns/1ns
module ucpc_top_tb;
	logic        core_clk = 1'h0;
	logic        rst_n = 1'h0;
	logic [2:0]  host_addr = 3'h0;
	logic [7:0]  host_data_in = 8'h00;
	logic        host_write_strobe_n = 1'h1;
	logic        host_read_strobe_n = 1'h1;
	logic        channel_a_select_n = 1'h1;
	logic        channel_b_select_n = 1'h1;
	logic        ring_indicator_a_n = 1'h1;
	logic        ring_indicator_b_n = 1'h1;
	logic        serial_in_a = 1'h1;
	logic        serial_in_b = 1'h1;
	logic        stall_a = 1'h0;
	logic        stall_b = 1'h0;
	logic        lb = 1'h0;
	logic        line_q = 1'h1;
	logic        line_b_q = 1'h1;
	logic        rx_chk = 1'h0;
	logic [2:0]  sin_q = 3'h7;
	logic [7:0]  host_data_out, tx_data_a, tx_data_b, rx_data_a, rx_data_b, v;
	logic        host_data_oe, serial_out_a, serial_out_b, request_to_send_a_n;
	logic        request_to_send_b_n, user_output_a, user_output_b, irq_out_a, irq_out_b;
	logic        irq_oe_a, irq_oe_b, receive_ready_a_n, receive_ready_b_n, transmit_ready_a_n;
	logic        transmit_ready_b_n, tx_valid_a, tx_valid_b, tx_ready_a, tx_ready_b;
	logic        tx_line_a, tx_line_b, rx_line_a, rx_line_b, rx_valid_a, rx_valid_b;
	logic        rx_ready_a, rx_ready_b;
	logic [31:0] seed = 32'h0000A951;
	logic [7:0]  exp_q[$];
	logic [7:0]  ctl_exp[2] = '{8'h00, 8'h00};
	int          n_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;

	ucpc_top u_dut (.core_clk, .rst_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe,
		.host_write_strobe_n, .host_read_strobe_n, .channel_a_select_n, .channel_b_select_n,
		.ring_indicator_a_n, .ring_indicator_b_n, .serial_in_a, .serial_in_b, .serial_out_a,
		.serial_out_b, .request_to_send_a_n, .request_to_send_b_n, .user_output_a,
		.user_output_b, .irq_out_a, .irq_out_b, .irq_oe_a, .irq_oe_b, .receive_ready_a_n,
		.receive_ready_b_n, .transmit_ready_a_n, .transmit_ready_b_n, .tx_data_a, .tx_data_b,
		.tx_valid_a, .tx_valid_b, .tx_ready_a, .tx_ready_b, .tx_line_a, .tx_line_b, .rx_line_a,
		.rx_line_b, .rx_data_a, .rx_data_b, .rx_valid_a, .rx_valid_b, .rx_ready_a, .rx_ready_b);
	ucpc_far u_far_a (.core_clk, .rst_n, .stall(stall_a), .tx_data(tx_data_a),
		.tx_valid(tx_valid_a), .tx_ready(tx_ready_a), .tx_line(tx_line_a), .rx_data(rx_data_a),
		.rx_valid(rx_valid_a), .rx_ready(rx_ready_a));
	ucpc_far u_far_b (.core_clk, .rst_n, .stall(stall_b), .tx_data(tx_data_b),
		.tx_valid(tx_valid_b), .tx_ready(tx_ready_b), .tx_line(tx_line_b), .rx_data(rx_data_b),
		.rx_valid(rx_valid_b), .rx_ready(rx_ready_b));

	always #5 core_clk = ~core_clk;

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk_pin(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// channel 2 selects neither channel
	task automatic sel(input int ch, input logic [2:0] a);
		cyc(1);
		host_addr <= a;
		channel_a_select_n <= ch != 0;
		channel_b_select_n <= ch != 1;
		cyc(3);
	endtask
	task automatic idle();
		cyc(4);
		channel_a_select_n <= 1'h1;
		channel_b_select_n <= 1'h1;
		cyc(4);
		#1;
		chk_pin("host_data_oe", 1'h0, host_data_oe);
	endtask
	task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] d);
		sel(ch, a);
		host_data_in <= d;
		host_write_strobe_n <= 1'h0;
		cyc(4);
		host_write_strobe_n <= 1'h1;
		idle();
	endtask
	task automatic rd(input int ch, input logic [2:0] a, output logic [7:0] d);
		sel(ch, a);
		host_read_strobe_n <= 1'h0;
		cyc(5);
		#1;
		d = host_data_out;
		chk_pin("host_data_oe", 1'h1, host_data_oe);
		cyc(1);
		host_read_strobe_n <= 1'h1;
		idle();
	endtask

	// serial pin watch: loopback keeps the pin idle, normal mode follows the line
	always @(posedge core_clk)
	begin
		cycles++;
		serial_in_a <= ^rnd();
		serial_in_b <= ^rnd();
		if (lb)
		begin
			chk_pin("serial_out_a", 1'h1, serial_out_a);
			chk_pin("rx_line_a", line_q, rx_line_a);
		end
		else if (rst_n)
			chk_pin("serial_out_a", line_q, serial_out_a);
		// two sync flops and the line flop stand behind the pin
		if (rx_chk)
			chk_pin("rx_line_a", sin_q[2], rx_line_a);
		if (rst_n)
			chk_pin("serial_out_b", line_b_q, serial_out_b);
		line_q <= tx_line_a;
		line_b_q <= tx_line_b;
		sin_q <= {sin_q[1:0], serial_in_a};
		if (cycles == 6000)
		begin
			n_errors++;
			stop_test();
		end
	end

	initial
	begin
		cyc(3);
		#1;
		chk_pin("user_output_a", 1'h1, user_output_a);
		chk_pin("request_to_send_a_n", 1'h1, request_to_send_a_n);
		chk_pin("irq_oe_b", 1'h0, irq_oe_b);
		chk_pin("serial_out_a", 1'h1, serial_out_a);
		chk_pin("rx_line_b", 1'h1, rx_line_b);
		cyc(3);
		rst_n <= 1'h1;
		$display("test reset done");
		for (int i = 0; i < 8; i++)
		begin
			ctl_exp[i[2]] = {4'h0, i[1], 1'h0, i[0], 1'h0};
			wr(i[2], ucpc_pkg::OFS_MODEM_CTL, ctl_exp[i[2]]);
			chk_pin("user_output_a", ~ctl_exp[0][3], user_output_a);
			chk_pin("irq_oe_a", ctl_exp[0][3], irq_oe_a);
			chk_pin("request_to_send_a_n", ~ctl_exp[0][1], request_to_send_a_n);
			chk_pin("user_output_b", ~ctl_exp[1][3], user_output_b);
			chk_pin("request_to_send_b_n", ~ctl_exp[1][1], request_to_send_b_n);
			rd(i[2], ucpc_pkg::OFS_MODEM_CTL, v);
			chk_byte("modem_control_reg", ctl_exp[i[2]], v);
		end
		wr(2, ucpc_pkg::OFS_MODEM_CTL, 8'h00);
		chk_pin("user_output_a", 1'h0, user_output_a);
		chk_pin("user_output_b", 1'h0, user_output_b);
		rd(0, 3'h3, v);
		chk_byte("unmapped", 8'h00, v);
		$display("test control pins done");
		rx_chk = 1'h1;
		for (int k = 0; k < 2; k++)
		begin
			wr(0, ucpc_pkg::OFS_IER, k ? 8'h00 : 8'h08);
			cyc(1);
			ring_indicator_a_n <= 1'h0;
			rd(0, ucpc_pkg::OFS_MODEM_STAT, v);
			chk_pin("ring level", 1'h1, v[6]);
			cyc(1);
			ring_indicator_a_n <= 1'h1;
			cyc(8);
			#1;
			chk_pin("irq_out_a", k == 0, irq_out_a);
			chk_pin("irq_out_b", 1'h0, irq_out_b);
			chk_pin("receive_ready_b_n", 1'h1, receive_ready_b_n);
			chk_pin("transmit_ready_b_n", 1'h0, transmit_ready_b_n);
			chk_pin("tx_valid_b", 1'h0, tx_valid_b);
			chk_pin("rx_ready_b", 1'h1, rx_ready_b);
			rd(0, ucpc_pkg::OFS_MODEM_STAT, v);
			chk_pin("ring end flag", 1'h1, v[2]);
			chk_pin("irq_out_a", 1'h0, irq_out_a);
		end
		$display("test ring done");
		wr(0, ucpc_pkg::OFS_ENH_FEAT, 8'h40);
		chk_pin("request_to_send_a_n", 1'h0, request_to_send_a_n);
		chk_pin("receive_ready_a_n", 1'h1, receive_ready_a_n);
		for (int k = 0; k < 3; k++)
		begin
			v = rnd();
			exp_q.push_back(v);
			u_far_a.send.push_back(v);
		end
		cyc(6);
		#1;
		chk_pin("receive_ready_a_n", 1'h0, receive_ready_a_n);
		chk_pin("rx_ready_a", 1'h0, rx_ready_a);
		chk_pin("request_to_send_a_n", 1'h1, request_to_send_a_n);
		repeat (4)
		begin
			rd(0, ucpc_pkg::OFS_DATA, v);
			chk_byte("rx data", exp_q.size() ? exp_q.pop_front() : 8'h00, v);
		end
		chk_pin("receive_ready_a_n", 1'h1, receive_ready_a_n);
		chk_pin("request_to_send_a_n", 1'h0, request_to_send_a_n);
		$display("test receive done");
		for (int f = 0; f < 2; f++)
		begin
			wr(0, ucpc_pkg::OFS_FCR, f[7:0]);
			cyc(1);
			stall_a <= 1'h1;
			for (int k = 0; k < 3; k++)
			begin
				v = rnd();
				if (k < 2)
					exp_q.push_back(v);
				wr(0, ucpc_pkg::OFS_DATA, v);
				chk_pin("transmit_ready_a_n", f ? k > 0 : 1'h1, transmit_ready_a_n);
			end
			cyc(1);
			stall_a <= 1'h0;
			cyc(30);
			#1;
			chk_pin("transmit_ready_a_n", 1'h0, transmit_ready_a_n);
			while (u_far_a.got.size() != 0)
				chk_byte("tx data", exp_q.pop_front(), u_far_a.got.pop_front());
			chk_pin("tx words left", 1'h0, exp_q.size() != 0);
		end
		// both buffers drained: transmit empty and not full, no data ready
		rd(0, ucpc_pkg::OFS_LSR, v);
		chk_byte("line status", 8'h60, v);
		$display("test transmit done");
		rx_chk = 1'h0;
		wr(0, ucpc_pkg::OFS_MODEM_CTL, 8'h1A);
		lb = 1'h1;
		wr(0, ucpc_pkg::OFS_DATA, rnd());
		cyc(15);
		lb = 1'h0;
		wr(0, ucpc_pkg::OFS_MODEM_CTL, 8'h0A);
		$display("test loopback done");
		stop_test();
	end
endmodule
